// File: design/pcs_regs.svh
// register indices, field positions, reset values and vector constants
// assumes an Avalon-MM byte address where byte address = 4 * index
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH
`define PCS_IDX_P0_LO 8'h84
`define PCS_IDX_P0_HI 8'h85
`define PCS_IDX_P1_LO 8'h94
`define PCS_IDX_P1_HI 8'h95
`define PCS_IDX_P2_LO 8'hAC
`define PCS_IDX_P2_HI 8'hAD
`define PCS_IDX_P3_LO 8'hB4
`define PCS_IDX_P3_HI 8'hB5
`define PCS_IDX_POL 8'hAE
`define PCS_IDX_XCTL 8'hC0
`define PCS_IDX_CFG_LO 8'hC2
`define PCS_IDX_CFG_HI 8'hC3
`define PCS_IDX_DATA 8'hD8
`define PCS_X3_PRIO 7
`define PCS_X3_EN 6
`define PCS_X3_PEND 5
`define PCS_X3_EDGE 4
`define PCS_X2_PRIO 3
`define PCS_X2_EN 2
`define PCS_X2_PEND 1
`define PCS_X2_EDGE 0
`define PCS_POL_POS 4
`define PCS_RST_BYTE 8'h00
`define PCS_RST_DATA 4'hF
`define PCS_VEC_LOW 3'h3
`define PCS_PIN_IRQ2 3
`define PCS_PIN_IRQ3 2
`define PCS_MASK_16 16'hFFFF
`define PCS_MASK_15 16'hFFFE
`define PCS_MASK_14 16'hFFFC
`define PCS_MASK_8 16'hFF00
`endif

// File: design/pcs_pkg.sv
// types shared by the port-four strobe block
// assumes pcs_regs.svh supplies the numeric constants
package pcs_pkg;
  typedef enum logic [1:0] {FUNC_GPIO, FUNC_RD, FUNC_WR, FUNC_RDWR} pcs_func_t;
  typedef enum logic [1:0] {CMP_16, CMP_15, CMP_14, CMP_8} pcs_cmp_t;
  typedef enum logic {BUS_IDLE, BUS_DONE} pcs_bus_state_t;
endpackage

// File: design/pcs_strobe_if.sv
// carrier between the port block and one strobe decoder
// assumes all signals are in the mclk_in domain
`timescale 1ns/1ns
interface pcs_strobe_if;
  import pcs_pkg::*;
  logic [15:0] base_addr;
  pcs_func_t   func;
  pcs_cmp_t    cmp;
  logic [15:0] ext_addr;
  logic        rd_act;
  logic        wr_act;
  logic        strobe_hit;
  modport cfg (output base_addr, func, cmp, ext_addr, rd_act, wr_act, input strobe_hit);
  modport dec (input base_addr, func, cmp, ext_addr, rd_act, wr_act, output strobe_hit);
endinterface

// File: design/pcs_strobe_dec.sv
// one chip-select decoder: masked address compare and strobe qualify
// assumes rd_act and wr_act are already active high
`timescale 1ns/1ns
`include "pcs_regs.svh"
module pcs_strobe_dec
  import pcs_pkg::*;
(
  pcs_strobe_if.dec sif  // configuration in, hit out
);
  logic [15:0] mask;
  logic        match;

  ////////////////////////////////////////////////////////////////////
  // compare length mask
  always_comb begin
    case (sif.cmp)
      CMP_16:  mask = `PCS_MASK_16;
      CMP_15:  mask = `PCS_MASK_15;
      CMP_14:  mask = `PCS_MASK_14;
      CMP_8:   mask = `PCS_MASK_8;
      default: mask = `PCS_MASK_16;
    endcase
  end

  assign match = ((sif.ext_addr ^ sif.base_addr) & mask) == 16'h0000;

  // write role fires on in-range write
  // role picks read, write or both
  always_comb begin
    case (sif.func)
      FUNC_RD:   sif.strobe_hit = match & sif.rd_act;
      FUNC_WR:   sif.strobe_hit = match & sif.wr_act;
      FUNC_RDWR: sif.strobe_hit = match & (sif.rd_act | sif.wr_act);
      default:   sif.strobe_hit = 1'b0;
    endcase
  end
endmodule

// File: design/pcs_port4.sv
// port-four block: gpio or chip-select strobes, two extra irqs,
// eight-source priority and vector logic, Avalon-MM register slave
// assumes the external bus and pins are synchronous to mclk_in
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ns
`include "pcs_regs.svh"

////////////////////////////////////////////////////////////////////
module pcs_port4
  import pcs_pkg::*;
(
  input  wire logic        mclk_in,             // 20 MHz core clock
  input  wire logic        rst_in,              // async reset, high
  input  wire logic [9:0]  avs_address_in,      // byte address
  input  wire logic        avs_read_in,         // read request
  input  wire logic        avs_write_in,        // write request
  input  wire logic [31:0] avs_writedata_in,    // write data
  input  wire logic [3:0]  avs_byteenable_in,   // lane 0 used
  output logic      [31:0] avs_readdata_out,    // registered read data
  output logic             avs_waitrequest_out, // stall
  input  wire logic [15:0] ext_addr_in,         // external data address
  input  wire logic        ext_rd_n_in,         // external read, low
  input  wire logic        ext_wr_n_in,         // external write, low
  input  wire logic [3:0]  pin_in,              // pin levels
  output logic      [3:0]  pin_out,             // pin drive value
  output logic      [3:0]  pin_oe_out,          // pin drive enable
  input  wire logic [5:0]  core_req_in,         // other six sources
  input  wire logic [5:0]  core_high_in,        // their priority bits
  input  wire logic        irq_service_in,      // vector taken, pulse
  output logic             irq_req_out,         // request pending
  output logic             irq_high_out,        // winner is high level
  output logic      [7:0]  irq_vector_out       // winner vector
);
  pcs_bus_state_t bus_state_reg;
  logic [7:0]  idx;
  logic        bus_req;
  logic        wr_en;
  logic [7:0]  wbyte;
  logic [7:0]  rd_mux;
  logic [31:0] readdata_reg;
  logic [7:0]  base_lo_reg [4];
  logic [7:0]  base_hi_reg [4];
  logic [7:0]  cfg_lo_reg;
  logic [7:0]  cfg_hi_reg;
  logic [3:0]  pol_reg;
  logic [7:0]  xctl_reg;
  logic [3:0]  data_reg;
  logic [3:0]  pin_out_reg;
  logic [3:0]  pin_oe_reg;
  logic [3:0]  strobe_hit;
  logic [1:0]  func_f [4];
  logic [1:0]  cmp_f [4];
  logic [1:0]  prev_reg;
  logic [1:0]  fall;
  logic [1:0]  x_req;
  logic [7:0]  all_req;
  logic [7:0]  all_high;
  logic [2:0]  win_idx;
  logic        win_any;
  logic        win_high;
  logic        irq_req_reg;
  logic        irq_high_reg;
  logic [2:0]  irq_idx_reg;
  logic [1:0]  svc_clr;

  ////////////////////////////////////////////////////////////////////
  // bus slave: one wait state, answer in second cycle
  assign idx     = avs_address_in[9:2];
  assign bus_req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = bus_req & (bus_state_reg == BUS_IDLE);
  assign wr_en   = avs_write_in & (bus_state_reg == BUS_DONE) & avs_byteenable_in[0];
  assign wbyte   = avs_writedata_in[7:0];
  assign avs_readdata_out = readdata_reg;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: bus_state_reg <= bus_req ? BUS_DONE : BUS_IDLE;
        BUS_DONE: bus_state_reg <= BUS_IDLE;
        default:  bus_state_reg <= BUS_IDLE;
      endcase
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    case (idx)
      `PCS_IDX_P0_LO:  rd_mux = base_lo_reg[0];
      `PCS_IDX_P0_HI:  rd_mux = base_hi_reg[0];
      `PCS_IDX_P1_LO:  rd_mux = base_lo_reg[1];
      `PCS_IDX_P1_HI:  rd_mux = base_hi_reg[1];
      `PCS_IDX_P2_LO:  rd_mux = base_lo_reg[2];
      `PCS_IDX_P2_HI:  rd_mux = base_hi_reg[2];
      `PCS_IDX_P3_LO:  rd_mux = base_lo_reg[3];
      `PCS_IDX_P3_HI:  rd_mux = base_hi_reg[3];
      // low nibble of polarity reads zero
      `PCS_IDX_POL:    rd_mux = {pol_reg, 4'h0};
      `PCS_IDX_XCTL:   rd_mux = xctl_reg;
      `PCS_IDX_CFG_LO: rd_mux = cfg_lo_reg;
      `PCS_IDX_CFG_HI: rd_mux = cfg_hi_reg;
      // reads see pin levels, as a port read does
      `PCS_IDX_DATA:   rd_mux = {4'h0, pin_in};
      default:         rd_mux = 8'h00;
    endcase
  end

  // read data latched at the stall edge, stands at the answer edge
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      readdata_reg <= 32'h0000_0000;
    end else if (avs_read_in && bus_state_reg == BUS_IDLE) begin
      readdata_reg <= {24'h00_0000, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // base address byte pairs per pin
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      base_lo_reg <= '{default: `PCS_RST_BYTE};
      base_hi_reg <= '{default: `PCS_RST_BYTE};
    end else if (wr_en) begin
      case (idx)
        `PCS_IDX_P0_LO: base_lo_reg[0] <= wbyte;
        `PCS_IDX_P0_HI: base_hi_reg[0] <= wbyte;
        `PCS_IDX_P1_LO: base_lo_reg[1] <= wbyte;
        `PCS_IDX_P1_HI: base_hi_reg[1] <= wbyte;
        `PCS_IDX_P2_LO: base_lo_reg[2] <= wbyte;
        `PCS_IDX_P2_HI: base_hi_reg[2] <= wbyte;
        `PCS_IDX_P3_LO: base_lo_reg[3] <= wbyte;
        `PCS_IDX_P3_HI: base_hi_reg[3] <= wbyte;
        default: ;
      endcase
    end
  end

  // mode, polarity and data registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_lo_reg <= `PCS_RST_BYTE;
      cfg_hi_reg <= `PCS_RST_BYTE;
      pol_reg    <= 4'h0;
      data_reg   <= `PCS_RST_DATA;
    end else if (wr_en) begin
      case (idx)
        `PCS_IDX_CFG_LO: cfg_lo_reg <= wbyte;
        `PCS_IDX_CFG_HI: cfg_hi_reg <= wbyte;
        `PCS_IDX_POL:    pol_reg <= wbyte[7:`PCS_POL_POS];
        `PCS_IDX_DATA:   data_reg <= wbyte[3:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // high config holds pin3 and pin2 fields
  assign func_f[3] = cfg_hi_reg[7:6];
  assign cmp_f[3]  = cfg_hi_reg[5:4];
  assign func_f[2] = cfg_hi_reg[3:2];
  assign cmp_f[2]  = cfg_hi_reg[1:0];
  // low config holds pin1 and pin0 fields
  assign func_f[1] = cfg_lo_reg[7:6];
  assign cmp_f[1]  = cfg_lo_reg[5:4];
  assign func_f[0] = cfg_lo_reg[3:2];
  assign cmp_f[0]  = cfg_lo_reg[1:0];

  pcs_strobe_if sif [4] ();

  // one decoder per pin
  for (genvar g = 0; g < 4; g++) begin : g_pin
    assign sif[g].base_addr = {base_hi_reg[g], base_lo_reg[g]};
    assign sif[g].func      = pcs_func_t'(func_f[g]);
    assign sif[g].cmp       = pcs_cmp_t'(cmp_f[g]);
    assign sif[g].ext_addr  = ext_addr_in;
    assign sif[g].rd_act    = ~ext_rd_n_in;
    assign sif[g].wr_act    = ~ext_wr_n_in;
    assign strobe_hit[g]    = sif[g].strobe_hit;
    pcs_strobe_dec u_dec (
      .sif (sif[g])
    );
  end

  // pin drive; strobes lag the external strobe by one clock
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_out_reg <= `PCS_RST_DATA;
      pin_oe_reg  <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (func_f[i] == FUNC_GPIO) begin
          pin_out_reg[i] <= data_reg[i];
          pin_oe_reg[i]  <= ~data_reg[i];
        end else begin
          // clear bit leaves the strobe active low
          pin_out_reg[i] <= pol_reg[i] ? strobe_hit[i] : ~strobe_hit[i];
          pin_oe_reg[i]  <= 1'b1;
        end
      end
    end
  end

  assign pin_out    = pin_out_reg;
  assign pin_oe_out = pin_oe_reg;

  ////////////////////////////////////////////////////////////////////
  // pin3 feeds irq two, pin2 feeds irq three
  assign fall[0] = prev_reg[0] & ~pin_in[`PCS_PIN_IRQ2] & (func_f[3] == FUNC_GPIO);
  assign fall[1] = prev_reg[1] & ~pin_in[`PCS_PIN_IRQ3] & (func_f[2] == FUNC_GPIO);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_reg <= 2'b11;
    end else begin
      prev_reg <= {pin_in[`PCS_PIN_IRQ3], pin_in[`PCS_PIN_IRQ2]};
    end
  end

  // service of the shown vector clears its flag
  assign svc_clr[0] = irq_service_in & irq_req_reg & (irq_idx_reg == 3'd6);
  assign svc_clr[1] = irq_service_in & irq_req_reg & (irq_idx_reg == 3'd7);

  // control bits plain; flags: hardware set beats any clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      xctl_reg <= `PCS_RST_BYTE;
    end else begin
      if (wr_en && idx == `PCS_IDX_XCTL) begin
        xctl_reg[`PCS_X3_PRIO] <= wbyte[`PCS_X3_PRIO];
        xctl_reg[`PCS_X3_EN]   <= wbyte[`PCS_X3_EN];
        // irq three edge bit at bit 4
        xctl_reg[`PCS_X3_EDGE] <= wbyte[`PCS_X3_EDGE];
        xctl_reg[`PCS_X2_PRIO] <= wbyte[`PCS_X2_PRIO];
        xctl_reg[`PCS_X2_EN]   <= wbyte[`PCS_X2_EN];
        xctl_reg[`PCS_X2_EDGE] <= wbyte[`PCS_X2_EDGE];
      end
      // edge sets flag, service clears it
      if (xctl_reg[`PCS_X2_EDGE] && fall[0]) begin
        xctl_reg[`PCS_X2_PEND] <= 1'b1;
      end else if (wr_en && idx == `PCS_IDX_XCTL) begin
        xctl_reg[`PCS_X2_PEND] <= wbyte[`PCS_X2_PEND];
      end else if (svc_clr[0] && xctl_reg[`PCS_X2_EDGE]) begin
        xctl_reg[`PCS_X2_PEND] <= 1'b0;
      end
      if (xctl_reg[`PCS_X3_EDGE] && fall[1]) begin
        xctl_reg[`PCS_X3_PEND] <= 1'b1;
      end else if (wr_en && idx == `PCS_IDX_XCTL) begin
        xctl_reg[`PCS_X3_PEND] <= wbyte[`PCS_X3_PEND];
      end else if (svc_clr[1] && xctl_reg[`PCS_X3_EDGE]) begin
        xctl_reg[`PCS_X3_PEND] <= 1'b0;
      end
    end
  end

  // edge mode uses flag, level mode the low pin
  assign x_req[0] = xctl_reg[`PCS_X2_EN] & (xctl_reg[`PCS_X2_EDGE] ? xctl_reg[`PCS_X2_PEND]
                    : (~pin_in[`PCS_PIN_IRQ2] & (func_f[3] == FUNC_GPIO)));
  assign x_req[1] = xctl_reg[`PCS_X3_EN] & (xctl_reg[`PCS_X3_EDGE] ? xctl_reg[`PCS_X3_PEND]
                    : (~pin_in[`PCS_PIN_IRQ3] & (func_f[2] == FUNC_GPIO)));

  assign all_req  = {x_req, core_req_in};
  // priority bits for the extra sources
  assign all_high = {xctl_reg[`PCS_X3_PRIO], xctl_reg[`PCS_X2_PRIO], core_high_in};

  ////////////////////////////////////////////////////////////////////
  // lowest index wins, high level searched first
  always_comb begin
    win_idx  = 3'd0;
    win_any  = 1'b0;
    win_high = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (all_req[i] && !all_high[i] && !win_any) begin
        win_idx = 3'(i);
      end
    end
    win_any = |all_req;
    for (int i = 7; i >= 0; i--) begin
      if (all_req[i] && all_high[i]) begin
        win_idx  = 3'(i);
        win_high = 1'b1;
      end
    end
  end

  // registered winner
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_req_reg  <= 1'b0;
      irq_high_reg <= 1'b0;
      irq_idx_reg  <= 3'd0;
    end else begin
      irq_req_reg  <= win_any;
      irq_high_reg <= win_high;
      irq_idx_reg  <= win_idx;
    end
  end

  // vector is index times eight plus three
  assign irq_vector_out = {2'b00, irq_idx_reg, `PCS_VEC_LOW};
  assign irq_req_out    = irq_req_reg;
  assign irq_high_out   = irq_high_reg;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_src3_high_wins: assert property (
    (x_req[1] && all_high[7] && !(|(all_req[6:0] & all_high[6:0])))
      |=> (irq_vector_out == 8'h3B) && irq_high_out)
    else $error("irq three high priority not chosen");

  a_disabled_quiet: assert property (
    (!xctl_reg[`PCS_X2_EN] && !xctl_reg[`PCS_X3_EN] && core_req_in == 6'h00)
      |=> !irq_req_out)
    else $error("request without enable");

  a_edge_sets_flag: assert property (
    (xctl_reg[`PCS_X2_EDGE] && func_f[3] == FUNC_GPIO && prev_reg[0]
      && !pin_in[`PCS_PIN_IRQ2]) |=> xctl_reg[`PCS_X2_PEND])
    else $error("falling edge did not set flag");

  a_level_no_flag: assert property (
    (!xctl_reg[`PCS_X2_EDGE] && !xctl_reg[`PCS_X2_PEND]
      && !(wr_en && idx == `PCS_IDX_XCTL)) |=> !xctl_reg[`PCS_X2_PEND])
    else $error("level mode set the flag");

  a_service_clears: assert property (
    (irq_service_in && irq_req_out && irq_vector_out == 8'h33
      && xctl_reg[`PCS_X2_EDGE] && !fall[0] && !wr_en) |=> !xctl_reg[`PCS_X2_PEND])
    else $error("service left flag set");

  a_vector_first: assert property (
    (core_req_in[0] && core_high_in[0]) |=> (irq_vector_out == 8'h03) && irq_req_out)
    else $error("source zero not first");

  a_gpio_drive: assert property (
    (func_f[0] == FUNC_GPIO) |=> (pin_oe_out[0] == !$past(data_reg[0]))
      && (pin_out[0] == $past(data_reg[0])))
    else $error("gpio pin drive wrong");

  a_write_strobe: assert property (
    (func_f[0] == FUNC_WR && cmp_f[0] == CMP_16 && pol_reg[0] && !ext_wr_n_in
      && ext_addr_in == {base_hi_reg[0], base_lo_reg[0]}) |=> pin_out[0] && pin_oe_out[0])
    else $error("write strobe missing");

  a_strobe_idle_low: assert property (
    (func_f[1] != FUNC_GPIO && !pol_reg[1] && ext_rd_n_in && ext_wr_n_in)
      |=> pin_out[1])
    else $error("idle strobe not high");

  a_pol_reserved: assert property (
    (avs_read_in && !avs_waitrequest_out && $past(idx) == `PCS_IDX_POL)
      |-> avs_readdata_out[3:0] == 4'h0)
    else $error("reserved polarity bits nonzero");

  a_bus_answer: assert property (
    (bus_req && bus_state_reg == BUS_IDLE) |=> !avs_waitrequest_out)
    else $error("no answer after one wait");

  c_write_strobe: cover property (pin_oe_out[0] && func_f[0] == FUNC_WR && pin_out[0]);
  c_irq3_vector: cover property (irq_req_out && irq_vector_out == 8'h3B);
  c_pend_set: cover property ($rose(xctl_reg[`PCS_X2_PEND]));
  c_bus_write: cover property (wr_en && idx == `PCS_IDX_CFG_LO);
endmodule

// File: dv/pcs_periph.sv
// far-side peripheral model: pull-ups and an external low driver per pin
// assumes the block drives a pin only while its enable is high
`timescale 1ns/1ns
module pcs_periph (
  input  wire logic [3:0] pin_out_in,  // block drive value
  input  wire logic [3:0] pin_oe_in,   // block drive enable
  input  wire logic [3:0] hold_low_in, // peripheral pulls pin low
  output logic      [3:0] pin_lvl_out  // resolved pin level
);
  // wired level: a released pin rises on its pull-up, never keeps a stale value
  assign pin_lvl_out = (pin_out_in | ~pin_oe_in) & ~hold_low_in;
endmodule

// File: dv/pcs_port4_tb_top.sv
// bench for the port-four strobe block: Avalon-MM tasks, strobe probes, irqs
// assumes the one-wait-state slave and one-cycle strobe lag of the block
`timescale 1ns/1ns
`include "pcs_regs.svh"
module pcs_port4_tb_top;
  logic        mclk_in, rst_in, bus_rd, bus_wr, ext_rd_n, ext_wr_n, svc, irq_req, irq_hi;
  logic [9:0]  bus_adr;
  logic [31:0] bus_wd, bus_q;
  logic [3:0]  bus_be, pin_lvl, pin_drv, pin_en, hold_low, s;
  logic [15:0] ext_adr;
  logic [5:0]  core_req, core_hi;
  logic [7:0]  irq_vec, cfg;
  logic        bus_wait;
  int          mismatches, checked;
  logic [7:0]  lo_idx [4] = '{`PCS_IDX_P0_LO, `PCS_IDX_P1_LO, `PCS_IDX_P2_LO, `PCS_IDX_P3_LO};
  logic [15:0] masks [4] = '{`PCS_MASK_16, `PCS_MASK_15, `PCS_MASK_14, `PCS_MASK_8};
  logic [15:0] offs [5] = '{16'h12B4, 16'h12B5, 16'h12B7, 16'h12F4, 16'h13B4};

  pcs_port4 dut (.mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(bus_adr),
    .avs_read_in(bus_rd), .avs_write_in(bus_wr), .avs_writedata_in(bus_wd),
    .avs_byteenable_in(bus_be), .avs_readdata_out(bus_q), .avs_waitrequest_out(bus_wait),
    .ext_addr_in(ext_adr), .ext_rd_n_in(ext_rd_n), .ext_wr_n_in(ext_wr_n),
    .pin_in(pin_lvl), .pin_out(pin_drv), .pin_oe_out(pin_en), .core_req_in(core_req),
    .core_high_in(core_hi), .irq_service_in(svc), .irq_req_out(irq_req),
    .irq_high_out(irq_hi), .irq_vector_out(irq_vec));
  pcs_periph periph (.pin_out_in(pin_drv), .pin_oe_in(pin_en), .hold_low_in(hold_low),
    .pin_lvl_out(pin_lvl));

  ////////////////////////////////////////
  // 20 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one bus cycle; waitrequest is looked at just before the edge it is sampled on
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge mclk_in);
    bus_adr <= {idx, 2'b00};
    bus_rd  <= !w;
    bus_wr  <= w;
    bus_wd  <= {24'h000000, d};
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (bus_wait !== 1'b0 && n < 20);
    if (n >= 20) begin
      mismatches++;
      tally_and_finish();
    end
    @(posedge mclk_in);
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(bus_q, {24'h000000, e});
  endtask

  // one external cycle, then the registered strobe is taken half a cycle later, at the next falling edge
  task automatic probe(input logic is_rd, input logic [15:0] a);
    @(posedge mclk_in);
    ext_adr  <= a;
    ext_rd_n <= !is_rd;
    ext_wr_n <= is_rd;
    @(posedge mclk_in);
    ext_rd_n <= 1'b1;
    ext_wr_n <= 1'b1;
    @(negedge mclk_in);
    s = pin_drv;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask

  ////////////////////////////////////////
  // hang guard
  initial begin
    repeat (90000) @(posedge mclk_in);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {rst_in, bus_rd, bus_wr, bus_adr, bus_wd, svc, core_req, core_hi} = '0;
    rst_in = 1'b1;
    {bus_be, ext_rd_n, ext_wr_n, ext_adr, hold_low} = {4'h1, 2'b11, 16'h0000, 4'h0};
    {mismatches, checked} = '0;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    tick(0);
    chk({bus_wait, pin_en, irq_req, irq_hi, irq_vec}, {1'b0, 4'h0, 2'b00, 8'h03});
    foreach (lo_idx[i]) begin
      rd_chk(lo_idx[i], 8'h00);
      rd_chk(lo_idx[i] + 8'h01, 8'h00);
    end
    rd_chk(`PCS_IDX_DATA, 8'h0F);
    bus(1'b1, `PCS_IDX_POL, 8'hFF);
    rd_chk(`PCS_IDX_POL, 8'hF0);
    bus_be <= 4'h0;
    bus(1'b1, `PCS_IDX_POL, 8'h00);
    bus_be <= 4'h1;
    rd_chk(`PCS_IDX_POL, 8'hF0);
    bus(1'b1, 8'h10, 8'hA5);
    rd_chk(8'h10, 8'h00);
    $display("test registers done");
    // gpio: a zero bit drives low, a one bit releases to the pull-up
    bus(1'b1, `PCS_IDX_DATA, 8'hF5);
    tick(1);
    chk({pin_en, pin_lvl}, {4'hA, 4'h5});
    rd_chk(`PCS_IDX_DATA, 8'h05);
    hold_low <= 4'h4;
    rd_chk(`PCS_IDX_DATA, 8'h01);
    hold_low <= 4'h0;
    bus(1'b1, `PCS_IDX_DATA, 8'h0F);
    $display("test gpio done");
    // every pin, role and compare length, polarity toggled with the length
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, lo_idx[p], offs[0][7:0]);
      bus(1'b1, lo_idx[p] + 8'h01, offs[0][15:8]);
      rd_chk(lo_idx[p] + 8'h01, offs[0][15:8]);
      for (int f = 1; f < 4; f++) begin
        for (int c = 0; c < 4; c++) begin
          cfg = 8'((f << (p[0] ? 6 : 2)) | (c << (p[0] ? 4 : 0)));
          bus(1'b1, `PCS_IDX_CFG_LO, p[1] ? 8'h00 : cfg);
          bus(1'b1, `PCS_IDX_CFG_HI, p[1] ? cfg : 8'h00);
          bus(1'b1, `PCS_IDX_POL, 8'(c[0] << (p + 4)));
          rd_chk(p[1] ? `PCS_IDX_CFG_HI : `PCS_IDX_CFG_LO, cfg);
          for (int k = 0; k < 10; k++) begin
            probe(k[0], offs[k / 2]);
            chk(s[p], ((((offs[k / 2] ^ offs[0]) & masks[c]) == 16'h0000) && (f == 3 ||
              (f == 1 && k[0]) || (f == 2 && !k[0]))) ? c[0] : !c[0]);
          end
        end
      end
    end
    bus(1'b1, `PCS_IDX_CFG_LO, 8'h00);
    bus(1'b1, `PCS_IDX_CFG_HI, 8'h00);
    $display("test strobes done");
    // edge-mode irq two on pin 3, cleared by service
    bus(1'b1, `PCS_IDX_XCTL, 8'h05);
    hold_low <= 4'h8;
    tick(3);
    chk({irq_req, irq_vec}, {1'b1, 8'h33});
    rd_chk(`PCS_IDX_XCTL, 8'h07);
    @(posedge mclk_in);
    svc <= 1'b1;
    @(posedge mclk_in);
    svc <= 1'b0;
    tick(3);
    chk(irq_req, 1'b0);
    rd_chk(`PCS_IDX_XCTL, 8'h05);
    // level-mode irq three on pin 2, disabled then enabled
    bus(1'b1, `PCS_IDX_XCTL, 8'h00);
    hold_low <= 4'h4;
    tick(3);
    chk(irq_req, 1'b0);
    bus(1'b1, `PCS_IDX_XCTL, 8'h40);
    tick(3);
    chk({irq_req, irq_hi, irq_vec}, {2'b10, 8'h3B});
    core_req <= 6'h3F;
    tick(3);
    chk(irq_vec, 8'h03);
    bus(1'b1, `PCS_IDX_XCTL, 8'hC0);
    tick(3);
    chk({irq_hi, irq_vec}, {1'b1, 8'h3B});
    hold_low <= 4'h0;
    core_hi <= 6'h20;
    tick(3);
    chk({irq_hi, irq_vec}, {1'b1, 8'h2B});
    // two high requests: source zero still polls first
    core_hi <= 6'h21;
    tick(3);
    chk({irq_hi, irq_vec}, {1'b1, 8'h03});
    core_hi <= 6'h00;
    for (int i = 0; i < 6; i++) begin
      core_req <= 6'(1 << i) | 6'h20;
      tick(3);
      chk(irq_vec, 8'h03 + 8'(8 * i));
    end
    // irq three in edge mode: its edge bit sits at bit 4, flag at bit 5
    bus(1'b1, `PCS_IDX_XCTL, 8'h50);
    hold_low <= 4'h4;
    tick(3);
    rd_chk(`PCS_IDX_XCTL, 8'h70);
    hold_low <= 4'h0;
    $display("test interrupts done");
    // mid-run reset brings registers and pins back to their reset state
    @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd_chk(`PCS_IDX_XCTL, 8'h00);
    rd_chk(`PCS_IDX_CFG_LO, 8'h00);
    rd_chk(`PCS_IDX_DATA, 8'h0F);
    chk({pin_en, irq_hi}, {4'h0, 1'b0});
    $display("test reset done");
    tally_and_finish();
  end
endmodule
